// *** bench/dprha_host_access_asserts.sv ***
// concurrent checks on the host-side ports of the shared ram access block
`timescale 1ns/10ps
`default_nettype none
module dprha_host_access_asserts (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [19:0] hostAddr,
    input wire logic [7:0]  hostDataIn,
    input wire logic        memRead,
    input wire logic        memWrite,
    input wire logic        ioRead,
    input wire logic        ioWrite,
    input wire logic [9:0]  memBaseSwitch,
    input wire logic [11:0] ioBaseSwitch,
    input wire logic [7:0]  hostDataOut_ff,
    input wire logic        hostDataOe_ff,
    input wire logic        hostReady_ff,
    input wire logic [6:0]  windowPage_ff
);
    logic       memHit;
    logic       selByte;
    logic [3:0] memQuiet_ff;
    // own window decode, so a decode slip in the design cannot hide behind it
    assign memHit  = hostAddr[19] && (hostAddr[18:9] == memBaseSwitch);
    assign selByte = memHit && (hostAddr[8:0] == 9'h0ff);
    // saturating idle count; saturation keeps it from wrapping back into the window
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            memQuiet_ff <= 4'h0;
        else if (memRead || memWrite)
            memQuiet_ff <= 4'h0;
        else if (memQuiet_ff != 4'hf)
            memQuiet_ff <= memQuiet_ff + 4'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_page_reset: assert property ($fell(reset) |-> windowPage_ff == 7'h00)
        else $error("window not on page zero after reset");
    a_page_select: assert property ($rose(memWrite) && selByte && windowPage_ff == 7'h00
        |-> ##[2:8] windowPage_ff == hostDataIn[6:0]) else $error("page write did not select page");
    a_page_return: assert property ($rose(memRead) && selByte && windowPage_ff != 7'h00
        |-> ##[2:10] windowPage_ff == 7'h00) else $error("select byte read did not return to page zero");
    a_page_keep: assert property (memQuiet_ff >= 4'h8 |-> $stable(windowPage_ff))
        else $error("page changed without a memory access");
    a_page_other: assert property ($rose(memWrite) && memHit && !selByte
        |-> ##1 $stable(windowPage_ff) [*8]) else $error("plain window write moved the page");
    a_oe_cause: assert property ($rose(hostDataOe_ff) |-> (memRead || ioRead) && $past(memRead || ioRead, 2))
        else $error("read data driven without a read strobe");
    a_oe_release: assert property ((!memRead && !ioRead) [*6] |-> !hostDataOe_ff)
        else $error("read data still driven after strobe release");
    a_data_hold: assert property (hostDataOe_ff && $past(hostDataOe_ff) |-> $stable(hostDataOut_ff))
        else $error("read data changed while driven");
    a_ready_idle: assert property ((!memRead && !memWrite && !ioRead && !ioWrite) [*8] |-> hostReady_ff)
        else $error("not ready after idle bus");
    c_page_pick: cover property ($rose(memWrite) && selByte && windowPage_ff == 7'h00);
    c_page_back: cover property ($rose(memRead) && selByte && windowPage_ff != 7'h00);
    c_io_read: cover property ($rose(hostDataOe_ff) && ioRead);
endmodule
bind dprha_host_access dprha_host_access_asserts u_dprha_host_access_asserts (
    .clk(clk), .reset(reset), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .memRead(memRead), .memWrite(memWrite), .ioRead(ioRead), .ioWrite(ioWrite),
    .memBaseSwitch(memBaseSwitch), .ioBaseSwitch(ioBaseSwitch), .hostDataOut_ff(hostDataOut_ff),
    .hostDataOe_ff(hostDataOe_ff), .hostReady_ff(hostReady_ff), .windowPage_ff(windowPage_ff)
);
`default_nettype wire

// *** bench/dprha_host_access_test.sv ***
// self-checking bench for the paged window and sector port access to the shared ram
`timescale 1ns/10ps
`default_nettype none
module dprha_host_access_test;
    // base switches are driven so a base change can be tried mid-run
    logic [9:0]  memSw;
    logic [11:0] ioSw;
    logic        clk;
    logic        reset;
    logic [19:0] hostAddr;
    logic [7:0]  hostDataIn;
    logic        memRead;
    logic        memWrite;
    logic        ioRead;
    logic        ioWrite;
    logic [7:0]  hostDataOut_ff;
    logic        hostDataOe_ff;
    logic        hostReady_ff;
    logic [6:0]  windowPage_ff;
    logic        hung;
    int          mismatches;
    int          num_checks;
    logic [8:0]  ports [5] = '{9'h000, 9'h004, 9'h005, 9'h006, 9'h00e};
    logic [7:0]  vals [5] = '{8'h0f, 8'h5a, 8'h01, 8'hc3, 8'h81};
    dprha_host_access u_dprha_host_access (
        .clk(clk), .reset(reset), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
        .memRead(memRead), .memWrite(memWrite), .ioRead(ioRead), .ioWrite(ioWrite),
        .memBaseSwitch(memSw), .ioBaseSwitch(ioSw), .hostDataOut_ff(hostDataOut_ff),
        .hostDataOe_ff(hostDataOe_ff), .hostReady_ff(hostReady_ff), .windowPage_ff(windowPage_ff)
    );
    dprha_host_model u_dprha_host_model (
        .clk(clk), .hostDataOut_ff(hostDataOut_ff), .hostDataOe_ff(hostDataOe_ff),
        .hostReady_ff(hostReady_ff), .hostAddr(hostAddr), .hostDataIn(hostDataIn), .memRead(memRead),
        .memWrite(memWrite), .ioRead(ioRead), .ioWrite(ioWrite), .hung(hung)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            num_checks++;
            if (got !== exp) begin
                mismatches++;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one access; for reads d is the expected byte
    task automatic op(input logic io, input logic wr, input logic [8:0] o, input logic [7:0] d);
        logic [7:0] q;
        begin
            u_dprha_host_model.acc(io, wr, io ? {4'h0, ioSw, o[3:0]} : {1'b1, memSw, o}, d, q);
            if (!wr)
                chk(q, d);
        end
    endtask
    task automatic final_report;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // a hung handshake counts as a mismatch and ends the run
    always @(posedge hung) begin
        mismatches++;
        final_report();
    end
    initial begin
        mismatches = 0;
        num_checks = 0;
        memSw = 10'h002;
        ioSw = 12'h010;
        reset = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        chk({1'b0, windowPage_ff}, 8'h00);
        for (int i = 0; i < 5; i++)
            op(1'b1, 1'b1, ports[i], vals[i]);
        for (int i = 0; i < 5; i++)
            op(1'b1, 1'b0, ports[i], vals[i]);
        op(1'b1, 1'b1, 9'h003, 8'h66);
        op(1'b1, 1'b0, 9'h003, 8'h00);
        // select page 33h, then write both halves of it through the window
        op(1'b0, 1'b1, 9'h0ff, 8'h33);
        chk({1'b0, windowPage_ff}, 8'h33);
        op(1'b0, 1'b1, 9'h010, 8'ha5);
        op(1'b0, 1'b1, 9'h1fe, 8'h5c);
        op(1'b0, 1'b1, 9'h0ff, 8'h77);
        chk({1'b0, windowPage_ff}, 8'h33);
        op(1'b0, 1'b0, 9'h0ff, 8'h77);
        chk({1'b0, windowPage_ff}, 8'h00);
        op(1'b0, 1'b0, 9'h0ff, 8'h33);
        op(1'b0, 1'b1, 9'h0ff, 8'h00);
        // restore the saved page and leave it again with no other access in between
        op(1'b0, 1'b1, 9'h0ff, 8'h33);
        chk({1'b0, windowPage_ff}, 8'h33);
        op(1'b0, 1'b0, 9'h0ff, 8'h77);
        chk({1'b0, windowPage_ff}, 8'h00);
        op(1'b0, 1'b1, 9'h0ff, 8'h00);
        op(1'b1, 1'b1, 9'h004, 8'h66);
        op(1'b1, 1'b1, 9'h005, 8'h00);
        op(1'b1, 1'b1, 9'h006, 8'h10);
        op(1'b1, 1'b0, 9'h00f, 8'ha5);
        op(1'b1, 1'b1, 9'h004, 8'h67);
        op(1'b1, 1'b1, 9'h006, 8'hfe);
        op(1'b1, 1'b0, 9'h00f, 8'h5c);
        op(1'b1, 1'b0, 9'h006, 8'hff);
        // offset wrap stays inside the sector
        op(1'b1, 1'b1, 9'h004, 8'h08);
        op(1'b1, 1'b1, 9'h006, 8'hfe);
        for (int i = 1; i < 4; i++)
            op(1'b1, 1'b1, 9'h00f, 8'h11 * i[7:0]);
        op(1'b1, 1'b0, 9'h006, 8'h01);
        op(1'b1, 1'b0, 9'h004, 8'h08);
        op(1'b0, 1'b1, 9'h0ff, 8'h04);
        op(1'b0, 1'b0, 9'h000, 8'h33);
        op(1'b0, 1'b0, 9'h0fe, 8'h11);
        op(1'b0, 1'b0, 9'h0ff, 8'h22);
        chk({1'b0, windowPage_ff}, 8'h00);
        op(1'b0, 1'b1, 9'h0ff, 8'h00);
        // swapped long word from an aligned offset, read back in stored order
        op(1'b1, 1'b1, 9'h000, 8'h10);
        op(1'b1, 1'b1, 9'h004, 8'h09);
        op(1'b1, 1'b1, 9'h006, 8'h00);
        for (int i = 0; i < 4; i++)
            op(1'b1, 1'b1, 9'h00f, 8'h01 + i[7:0]);
        op(1'b1, 1'b1, 9'h000, 8'h00);
        op(1'b1, 1'b1, 9'h006, 8'h00);
        for (int i = 0; i < 4; i++)
            op(1'b1, 1'b0, 9'h00f, 8'h04 - i[7:0]);
        // window at the top of its range, ports at the top of i/o space
        #1;
        memSw = 10'h3ff;
        ioSw = 12'hfff;
        op(1'b0, 1'b1, 9'h0fe, 8'h9e);
        op(1'b1, 1'b1, 9'h004, 8'h2d);
        op(1'b1, 1'b0, 9'h004, 8'h2d);
        #1;
        memSw = 10'h002;
        op(1'b0, 1'b0, 9'h0fe, 8'h9e);
        final_report();
    end
endmodule
`default_nettype wire

// *** bench/dprha_host_model.sv ***
// host processor model: strobed memory and port cycles on the expansion bus
`timescale 1ns/10ps
`default_nettype none
module dprha_host_model (
    input wire logic        clk,
    input wire logic [7:0]  hostDataOut_ff,
    input wire logic        hostDataOe_ff,
    input wire logic        hostReady_ff,
    output var logic [19:0] hostAddr,
    output var logic [7:0]  hostDataIn,
    output wire logic       memRead,
    output wire logic       memWrite,
    output wire logic       ioRead,
    output wire logic       ioWrite,
    output var logic        hung
);
    logic [3:0] strb;
    assign {memRead, memWrite, ioRead, ioWrite} = strb;
    initial begin
        strb = 4'h0;
        hostAddr = 20'h00000;
        hostDataIn = 8'h00;
        hung = 1'b0;
    end
    // one cycle; address and data hold until the answer, then the bus shows inverted values
    task automatic acc(input logic io, input logic wr, input logic [19:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        begin
            n = 0;
            @(posedge clk);
            #1;
            hostAddr = a;
            hostDataIn = d;
            strb = {!io && !wr, !io && wr, io && !wr, io && wr};
            repeat (6) @(posedge clk);
            while ((wr ? hostReady_ff : hostDataOe_ff) !== 1'b1 && n < 60) begin
                @(posedge clk);
                n++;
            end
            q = hostDataOut_ff;
            if (n >= 60) begin
                $display("[ERR] %0t host cycle never answered", $time);
                hung = 1'b1;
            end
            #1;
            strb = 4'h0;
            hostAddr = ~a;
            hostDataIn = ~d;
            n = 0;
            // the gap between strobes must outlast the input synchroniser
            while (hostDataOe_ff !== 1'b0 && n < 20) begin
                @(posedge clk);
                n++;
            end
            repeat (3) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// *** logic/dprha_fifo.v ***
// command fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module dprha_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             reset,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW:0]      wrPtr_ff;
    reg [AW:0]      rdPtr_ff;

    // extra pointer bit separates full from empty
    wire empty = (wrPtr_ff == rdPtr_ff);
    wire full  = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);

    assign inReady  = ~full;
    assign outValid = ~empty;
    assign outData  = store[rdPtr_ff[AW-1:0]];

    // storage has no reset; only the pointers define state
    always @(posedge clk) begin
        if (inValid && !full) begin
            store[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    // pointer update
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wrPtr_ff <= {(AW+1){1'b0}};
            rdPtr_ff <= {(AW+1){1'b0}};
        end else begin
            if (inValid && !full) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (outReady && !empty) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// *** logic/dprha_host_access.v ***
// host bus access logic: paged memory window and port-mapped sector access to the shared ram
`timescale 1ns/10ps
`default_nettype none
`include "dprha_regs.vh"

module dprha_host_access (
    input  wire        clk,
    input  wire        reset,
    input  wire [19:0] hostAddr,
    input  wire [7:0]  hostDataIn,
    input  wire        memRead,
    input  wire        memWrite,
    input  wire        ioRead,
    input  wire        ioWrite,
    input  wire [9:0]  memBaseSwitch,
    input  wire [11:0] ioBaseSwitch,
    output reg  [7:0]  hostDataOut_ff,
    output reg         hostDataOe_ff,
    output reg         hostReady_ff,
    output reg  [6:0]  windowPage_ff
);
    localparam ST_IDLE   = 2'd0;
    localparam ST_RDWAIT = 2'd1;
    localparam ST_FIXUP  = 2'd2;

    // two-stage synchronisers plus one stage for edge detection
    reg [19:0] addrS1_ff;
    reg [19:0] addrS2_ff;
    reg [7:0]  dataS1_ff;
    reg [7:0]  dataS2_ff;
    reg [9:0]  memBaseS1_ff;
    reg [9:0]  memBaseS2_ff;
    reg [11:0] ioBaseS1_ff;
    reg [11:0] ioBaseS2_ff;
    reg [3:0]  strbS1_ff;
    reg [3:0]  strbS2_ff;
    reg [3:0]  strbS3_ff;

    reg [1:0]  state_ff;
    reg [7:0]  control_ff;
    reg [7:0]  sectorLow_ff;
    reg [7:0]  sectorHigh_ff;
    reg [7:0]  sectorOfs_ff;
    reg [7:0]  redundancy_ff;
    reg        cmdValid_ff;
    reg [17:0] cmdWord_ff;
    reg        rdReq_ff;
    reg        rdIsIo_ff;
    reg [8:0]  rdOfs_ff;

    wire        fifoInReady;
    wire        fifoOutValid;
    wire [17:0] fifoOutData;
    wire        fifoOutReady;
    wire [7:0]  ramRdata;

    reg         ramWe;
    reg  [15:0] ramAddr;
    reg  [7:0]  ramWdata;
    reg  [7:0]  swapOfs;
    reg  [15:0] sectorAddr;
    reg  [7:0]  portRead;

    // strobe order: memRead, memWrite, ioRead, ioWrite
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            addrS1_ff    <= 20'h00000;
            addrS2_ff    <= 20'h00000;
            dataS1_ff    <= 8'h00;
            dataS2_ff    <= 8'h00;
            memBaseS1_ff <= 10'h000;
            memBaseS2_ff <= 10'h000;
            ioBaseS1_ff  <= 12'h000;
            ioBaseS2_ff  <= 12'h000;
            strbS1_ff    <= 4'h0;
            strbS2_ff    <= 4'h0;
            strbS3_ff    <= 4'h0;
        end else begin
            addrS1_ff    <= hostAddr;
            addrS2_ff    <= addrS1_ff;
            dataS1_ff    <= hostDataIn;
            dataS2_ff    <= dataS1_ff;
            memBaseS1_ff <= memBaseSwitch;
            memBaseS2_ff <= memBaseS1_ff;
            ioBaseS1_ff  <= ioBaseSwitch;
            ioBaseS2_ff  <= ioBaseS1_ff;
            strbS1_ff    <= {ioWrite, ioRead, memWrite, memRead};
            strbS2_ff    <= strbS1_ff;
            strbS3_ff    <= strbS2_ff;
        end
    end

    wire [3:0] strbEdge = strbS2_ff & ~strbS3_ff;
    // window needs address bit 19 set, so bases run 80000h..ffe00h in 200h steps
    wire memHit = addrS2_ff[`DPRHA_WIN_SEL_BIT] && (addrS2_ff[18:9] == memBaseS2_ff);
    wire ioHit  = (addrS2_ff[15:4] == ioBaseS2_ff);
    wire readLevel = strbS2_ff[0] | strbS2_ff[2];

    wire [8:0] popOfs  = fifoOutData[16:8];
    wire [7:0] popData = fifoOutData[7:0];
    wire       popIsIo = fifoOutData[17];
    wire       popNow  = fifoOutValid && (state_ff == ST_IDLE);

    assign fifoOutReady = (state_ff == ST_IDLE);

    // ram port steering; buffered writes always drain before a read is served
    always @* begin
        ramWe    = 1'b0;
        ramAddr  = 16'h0000;
        ramWdata = 8'h00;
        // inverting the two low offset bits flips byte order in a long word
        if (control_ff[`DPRHA_CTRL_SWAP_BIT]) begin
            swapOfs = {sectorOfs_ff[7:2], ~sectorOfs_ff[1:0]};
        end else begin
            swapOfs = sectorOfs_ff;
        end
        // only 256 sectors exist in 64k, so the high sector byte is storage only
        sectorAddr = {sectorLow_ff, swapOfs};
        case (state_ff)
            ST_IDLE: begin
                if (fifoOutValid) begin
                    if (!popIsIo) begin
                        ramWe    = 1'b1;
                        ramWdata = popData;
                        ramAddr  = {windowPage_ff, popOfs};
                    end else if (popOfs[3:0] == `DPRHA_PORT_DATA) begin
                        ramWe    = 1'b1;
                        ramWdata = popData;
                        ramAddr  = sectorAddr;
                    end
                end else if (rdReq_ff) begin
                    if (rdIsIo_ff) begin
                        ramAddr = sectorAddr;
                    end else begin
                        ramAddr = {windowPage_ff, rdOfs_ff};
                    end
                end
            end
            ST_FIXUP: begin
                ramWe    = 1'b1;
                ramAddr  = {`DPRHA_PAGE_ZERO, `DPRHA_PAGE_SEL_OFS};
                ramWdata = {1'b0, windowPage_ff};
            end
            default: begin
                ramWe = 1'b0;
            end
        endcase
    end

    // readback of the plain port registers; unused offsets read zero
    always @* begin
        case (rdOfs_ff[3:0])
            `DPRHA_PORT_CTRL:   portRead = control_ff;
            `DPRHA_PORT_SECLO:  portRead = sectorLow_ff;
            `DPRHA_PORT_SECHI:  portRead = sectorHigh_ff;
            `DPRHA_PORT_SECOFS: portRead = sectorOfs_ff;
            `DPRHA_PORT_REDUN:  portRead = redundancy_ff;
            default:            portRead = 8'h00;
        endcase
    end

    // request capture, command engine and host handshake
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff       <= ST_IDLE;
            control_ff     <= `DPRHA_CTRL_RST;
            sectorLow_ff   <= `DPRHA_SEC_RST;
            sectorHigh_ff  <= `DPRHA_SEC_RST;
            sectorOfs_ff   <= `DPRHA_SEC_RST;
            redundancy_ff  <= `DPRHA_REDUN_RST;
            windowPage_ff  <= `DPRHA_PAGE_ZERO;
            cmdValid_ff    <= 1'b0;
            cmdWord_ff     <= 18'h00000;
            rdReq_ff       <= 1'b0;
            rdIsIo_ff      <= 1'b0;
            rdOfs_ff       <= 9'h000;
            hostDataOut_ff <= 8'h00;
            hostDataOe_ff  <= 1'b0;
            hostReady_ff   <= 1'b1;
        end else begin
            // bus released once the host drops its read strobe
            if (!readLevel) begin
                hostDataOe_ff <= 1'b0;
            end
            // a write waits here while the fifo is full, holding ready low
            if (cmdValid_ff && fifoInReady) begin
                cmdValid_ff <= 1'b0;
            end
            if (strbEdge[1] && memHit) begin
                cmdValid_ff <= 1'b1;
                cmdWord_ff  <= {1'b0, addrS2_ff[8:0], dataS2_ff};
            end else if (strbEdge[3] && ioHit) begin
                cmdValid_ff <= 1'b1;
                cmdWord_ff  <= {1'b1, 5'h00, addrS2_ff[3:0], dataS2_ff};
            end
            if (strbEdge[0] && memHit) begin
                rdReq_ff  <= 1'b1;
                rdIsIo_ff <= 1'b0;
                rdOfs_ff  <= addrS2_ff[8:0];
            end else if (strbEdge[2] && ioHit) begin
                rdReq_ff  <= 1'b1;
                rdIsIo_ff <= 1'b1;
                rdOfs_ff  <= {5'h00, addrS2_ff[3:0]};
            end
            hostReady_ff <= ~(cmdValid_ff | rdReq_ff | (strbEdge[1] & memHit) | (strbEdge[3] & ioHit)
                              | (strbEdge[0] & memHit) | (strbEdge[2] & ioHit));

            case (state_ff)
                ST_IDLE: begin
                    if (popNow) begin
                        if (!popIsIo) begin
                            // selecting a page only works while page 0 is shown
                            if (popOfs == `DPRHA_PAGE_SEL_OFS && windowPage_ff == `DPRHA_PAGE_ZERO) begin
                                windowPage_ff <= popData[6:0];
                            end
                        end else begin
                            case (popOfs[3:0])
                                `DPRHA_PORT_CTRL:   control_ff    <= popData;
                                `DPRHA_PORT_SECLO:  sectorLow_ff  <= popData;
                                `DPRHA_PORT_SECHI:  sectorHigh_ff <= popData;
                                `DPRHA_PORT_SECOFS: sectorOfs_ff  <= popData;
                                `DPRHA_PORT_REDUN:  redundancy_ff <= popData;
                                `DPRHA_PORT_DATA:   sectorOfs_ff  <= sectorOfs_ff + 8'h01;
                                default:            sectorOfs_ff  <= sectorOfs_ff;
                            endcase
                        end
                    end else if (rdReq_ff && !cmdValid_ff) begin
                        if (!rdIsIo_ff) begin
                            state_ff <= ST_RDWAIT;
                        end else if (rdOfs_ff[3:0] == `DPRHA_PORT_DATA) begin
                            state_ff     <= ST_RDWAIT;
                            sectorOfs_ff <= sectorOfs_ff + 8'h01;
                        end else begin
                            hostDataOut_ff <= portRead;
                            hostDataOe_ff  <= 1'b1;
                            rdReq_ff       <= 1'b0;
                        end
                    end
                end
                ST_RDWAIT: begin
                    hostDataOut_ff <= ramRdata;
                    hostDataOe_ff  <= 1'b1;
                    rdReq_ff       <= 1'b0;
                    // the old page number must reach page 0 before the window moves
                    if (!rdIsIo_ff && rdOfs_ff == `DPRHA_PAGE_SEL_OFS && windowPage_ff != `DPRHA_PAGE_ZERO) begin
                        state_ff <= ST_FIXUP;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_FIXUP: begin
                    windowPage_ff <= `DPRHA_PAGE_ZERO;
                    state_ff      <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    dprha_fifo #(
        .WIDTH (18),
        .DEPTH (16),
        .AW    (4)
    ) u_fifo (
        .clk      (clk),
        .reset    (reset),
        .inValid  (cmdValid_ff),
        .inReady  (fifoInReady),
        .inData   (cmdWord_ff),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    dprha_ram u_ram (
        .clk   (clk),
        .we    (ramWe),
        .addr  (ramAddr),
        .wdata (ramWdata),
        .rdata (ramRdata)
    );
endmodule

`default_nettype wire

// *** logic/dprha_ram.v ***
// 64k x 8 shared ram with registered read
`timescale 1ns/10ps
`default_nettype none

module dprha_ram (
    input  wire        clk,
    input  wire        we,
    input  wire [15:0] addr,
    input  wire [7:0]  wdata,
    output reg  [7:0]  rdata
);
    reg [7:0] mem [0:65535];

    // one port serves both addressing modes, so both see the same bytes
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

`default_nettype wire

// *** logic/dprha_regs.vh ***
// register offsets, field positions and reset values of the dual-port ram host access block
`ifndef DPRHA_REGS_VH
`define DPRHA_REGS_VH

// port-mapped register offsets within the 16-port block
`define DPRHA_PORT_CTRL      4'h0
`define DPRHA_PORT_SECLO     4'h4
`define DPRHA_PORT_SECHI     4'h5
`define DPRHA_PORT_SECOFS    4'h6
`define DPRHA_PORT_REDUN     4'he
`define DPRHA_PORT_DATA      4'hf

// memory-mapped window
`define DPRHA_PAGE_SEL_OFS   9'h0ff
`define DPRHA_PAGE_ZERO      7'h00
`define DPRHA_WIN_SEL_BIT    19

// control register fields
`define DPRHA_CTRL_SWAP_BIT  4

// reset values
`define DPRHA_CTRL_RST       8'h00
`define DPRHA_SEC_RST        8'h00
`define DPRHA_REDUN_RST      8'h00

`endif
